// ===== rtl/ecs_clock_select.sv
// Sample-clock source selection, band setting and extra clock divider
`timescale 1ns/1ps

module ecs_clock_select
  import ecs_pkg::*;
#(
  parameter int REG_AW = 16,
  parameter int REG_DW = 32
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register access
  input wire logic [REG_AW-1:0] REG_ADDR_I,
  input wire logic [REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [REG_DW-1:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Board setup seen by this block
  input wire logic [3:0] CH_ENABLE_I,
  input wire logic FIFO_MODE_I,
  input wire logic [31:0] SAMPLE_RATE_I,
  input wire logic CLK_OUT_EN_I,
  input wire logic RUN_I,
  // Clock sources
  input wire logic EXT_CLK_I,
  input wire logic PLL_TICK_I,
  // Clock path controls
  output logic CLK_SRC_EXT_O,
  output logic TERM_EN_O,
  output logic [5:0] BAND_CODE_O,
  output logic BAND_ERR_O,
  output logic [ECS_DIV_W-1:0] DIV_ACTIVE_O,
  output logic SAMPLE_TICK_O
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Nearest permitted factor; a tie keeps the smaller one
  function automatic logic [ECS_DIV_W-1:0] nearest_factor(
    input logic [31:0] want
  );
    logic [31:0] best_diff;
    logic [31:0] diff;
    logic [31:0] fac;
    logic [ECS_DIV_W-1:0] best;
    best = ECS_FACTORS[0];
    best_diff = 32'hffff_ffff;
    for (int i = 0; i < ECS_NUM_FACTORS; i++) begin
      fac = {21'h0, ECS_FACTORS[i]};
      diff = (want > fac) ? (want - fac) : (fac - want);
      if (diff < best_diff) begin
        best_diff = diff;
        best = ECS_FACTORS[i];
      end
    end
    return best;
  endfunction

  function automatic logic band_code_valid(input logic [31:0] code);
    return (code == {26'h0, ECS_BAND_SINGLE}) ||
           (code == {26'h0, ECS_BAND_BURST_SMALL}) ||
           (code == {26'h0, ECS_BAND_BURST_MEDIUM}) ||
           (code == {26'h0, ECS_BAND_BURST_LARGE}) ||
           (code == {26'h0, ECS_BAND_BURST_EXTRA_LARGE});
  endfunction

  // ---------------------------------------------------------------------
  // Software-visible settings
  // ---------------------------------------------------------------------
  logic ext_sel_q;
  logic ext_sel_d;
  logic term_q;
  logic term_d;
  logic [5:0] band_q;
  logic [5:0] band_d;
  logic [ECS_DIV_W-1:0] div_q;
  logic [ECS_DIV_W-1:0] div_d;
  logic [31:0] div_want;

  always_comb begin
    ext_sel_d = ext_sel_q;
    term_d = term_q;
    band_d = band_q;
    div_d = div_q;
    div_want = REG_WDATA_I;
    // Internal slow rates fold their division into the shared divider
    if (!ext_sel_q && SAMPLE_RATE_I != 32'h0 &&
        SAMPLE_RATE_I < ECS_DIV_SHARE_HZ) begin
      div_want = ECS_DIV_SHARE_HZ / SAMPLE_RATE_I;
    end
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        ECS_REG_EXT_SEL: begin
          ext_sel_d = REG_WDATA_I[0];
        end
        ECS_REG_TERM: begin
          term_d = REG_WDATA_I[0];
        end
        ECS_REG_BAND: begin
          // Unknown codes are dropped so the path never sees one
          if (band_code_valid(REG_WDATA_I)) begin
            band_d = REG_WDATA_I[5:0];
          end
        end
        ECS_REG_DIVIDER: begin
          // Resolved now, so rate and source must already be set
          div_d = nearest_factor(div_want);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ext_sel_q <= ECS_RST_EXT_SEL;
      term_q <= ECS_RST_TERM;
      band_q <= ECS_RST_BAND;
      div_q <= ECS_RST_DIVIDER;
    end else begin
      ext_sel_q <= ext_sel_d;
      term_q <= term_d;
      band_q <= band_d;
      div_q <= div_d;
    end
  end

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  logic [REG_DW-1:0] rdata_q;
  logic [REG_DW-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = REG_RD_I;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        ECS_REG_EXT_SEL: rdata_d = {{(REG_DW-1){1'b0}}, ext_sel_q};
        ECS_REG_TERM: rdata_d = {{(REG_DW-1){1'b0}}, term_q};
        ECS_REG_BAND: rdata_d = {{(REG_DW-6){1'b0}}, band_q};
        ECS_REG_DIVIDER: begin
          rdata_d = {{(REG_DW-ECS_DIV_W){1'b0}}, div_q};
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------------
  // Settings in force during replay
  // ---------------------------------------------------------------------
  logic run_q;
  logic run_d;
  logic act_ext_q;
  logic act_ext_d;
  logic [5:0] act_band_q;
  logic [5:0] act_band_d;
  logic [ECS_DIV_W-1:0] act_div_q;
  logic [ECS_DIV_W-1:0] act_div_d;
  logic term_en_q;
  logic term_en_d;
  logic band_err_q;
  logic band_err_d;
  logic four_fifo;
  logic run_start;

  always_comb begin
    run_d = RUN_I;
    run_start = RUN_I && !run_q;
    act_ext_d = act_ext_q;
    act_band_d = act_band_q;
    act_div_d = act_div_q;
    // Swapping sources mid-replay would glitch the sample clock
    if (run_start) begin
      act_ext_d = ext_sel_q;
      act_band_d = band_q;
      act_div_d = div_q;
    end
    // Load only helps while the connector is not driven by the board
    term_en_d = 1'b0;
    if (ext_sel_q || !CLK_OUT_EN_I) begin
      term_en_d = term_q;
    end
    // Only four channels in FIFO mode have the upper three bands
    four_fifo = (CH_ENABLE_I == 4'hf) && FIFO_MODE_I;
    band_err_d = 1'b0;
    if (!four_fifo) begin
      band_err_d = band_q != ECS_BAND_SINGLE &&
                   band_q != ECS_BAND_BURST_SMALL;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      run_q <= 1'b0;
      act_ext_q <= ECS_RST_EXT_SEL;
      act_band_q <= ECS_RST_BAND;
      act_div_q <= ECS_RST_DIVIDER;
      term_en_q <= 1'b0;
      band_err_q <= 1'b0;
    end else begin
      run_q <= run_d;
      act_ext_q <= act_ext_d;
      act_band_q <= act_band_d;
      act_div_q <= act_div_d;
      term_en_q <= term_en_d;
      band_err_q <= band_err_d;
    end
  end

  // ---------------------------------------------------------------------
  // Source select and extra divider
  // ---------------------------------------------------------------------
  // The connector clock is taken as a level sampled on the core clock,
  // so only rates below half the core rate are counted faithfully.
  logic ext_clk_q;
  logic ext_clk_d;
  logic [ECS_DIV_W-1:0] cnt_q;
  logic [ECS_DIV_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic src_edge;

  always_comb begin
    ext_clk_d = EXT_CLK_I;
    src_edge = act_ext_q ? (EXT_CLK_I && !ext_clk_q)
                         : PLL_TICK_I;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    // A restart clears the count, so the first sample waits a full period
    if (run_start || !RUN_I) begin
      cnt_d = '0;
    end else if (src_edge) begin
      if (cnt_q >= act_div_q - 11'h001) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ext_clk_q <= 1'b0;
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      ext_clk_q <= ext_clk_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign REG_RDATA_O = rdata_q;
  assign REG_RVALID_O = rvalid_q;
  assign CLK_SRC_EXT_O = act_ext_q;
  assign TERM_EN_O = term_en_q;
  assign BAND_CODE_O = act_band_q;
  assign BAND_ERR_O = band_err_q;
  assign DIV_ACTIVE_O = act_div_q;
  assign SAMPLE_TICK_O = tick_q;

endmodule // ecs_clock_select

// ===== rtl/ecs_pkg.sv
// Constants shared by the sample-clock source selection block
package ecs_pkg;

  // ---------------------------------------------------------------------
  // Register numbers, as software addresses them
  // ---------------------------------------------------------------------
  localparam logic [15:0] ECS_REG_DIVIDER = 16'h4e48;
  localparam logic [15:0] ECS_REG_EXT_SEL = 16'h4e84;
  localparam logic [15:0] ECS_REG_TERM = 16'h4e98;
  localparam logic [15:0] ECS_REG_BAND = 16'h4ea2;

  // ---------------------------------------------------------------------
  // External clock band codes
  // ---------------------------------------------------------------------
  localparam logic [5:0] ECS_BAND_SINGLE = 6'h02;
  localparam logic [5:0] ECS_BAND_BURST_SMALL = 6'h04;
  localparam logic [5:0] ECS_BAND_BURST_MEDIUM = 6'h08;
  localparam logic [5:0] ECS_BAND_BURST_LARGE = 6'h10;
  localparam logic [5:0] ECS_BAND_BURST_EXTRA_LARGE = 6'h20;

  // ---------------------------------------------------------------------
  // Divider factors and field widths
  // ---------------------------------------------------------------------
  localparam int ECS_DIV_W = 11;
  localparam int ECS_NUM_FACTORS = 17;
  localparam logic [ECS_DIV_W-1:0] ECS_FACTORS [ECS_NUM_FACTORS] = '{
    11'h001, 11'h002, 11'h004, 11'h008, 11'h00a, 11'h010, 11'h014,
    11'h028, 11'h032, 11'h050, 11'h064, 11'h0c8, 11'h190, 11'h1f4,
    11'h320, 11'h3e8, 11'h7d0
  };

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic ECS_RST_EXT_SEL = 1'b0;
  localparam logic ECS_RST_TERM = 1'b0;
  localparam logic [5:0] ECS_RST_BAND = ECS_BAND_SINGLE;
  localparam logic [ECS_DIV_W-1:0] ECS_RST_DIVIDER = 11'h001;

  // ---------------------------------------------------------------------
  // Rates
  // ---------------------------------------------------------------------
  // Sum rate below which the internal path borrows the extra divider
  localparam logic [31:0] ECS_DIV_SHARE_HZ = 32'h000f_4240;
  // Fixed internal reference that feeds the PLL
  localparam logic [31:0] ECS_REF_HZ = 32'h0262_5a00;

endpackage : ecs_pkg

// ===== sim/ecs_clock_select_monitor.sv
// Port checker for the sample-clock source selection block
`timescale 1ns/1ps
// ------------
// Port checker
// ------------
module ecs_clock_select_mon
  import ecs_pkg::*;
#(
  parameter int REG_DW = 32
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register read
  input wire logic REG_RD_I,
  input wire logic [REG_DW-1:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  // Replay and sources
  input wire logic RUN_I,
  input wire logic EXT_CLK_I,
  input wire logic PLL_TICK_I,
  // Clock path
  input wire logic CLK_SRC_EXT_O,
  input wire logic [5:0] BAND_CODE_O,
  input wire logic [ECS_DIV_W-1:0] DIV_ACTIVE_O,
  input wire logic SAMPLE_TICK_O
);
  logic div_ok;
  always_comb begin
    div_ok = 1'b0;
    for (int k = 0; k < ECS_NUM_FACTORS; k++) begin
      if (DIV_ACTIVE_O == ECS_FACTORS[k]) begin
        div_ok = 1'b1;
      end
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  read_answer_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered");
  rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved");
  // Two clock edges back, so the start copy itself is not flagged
  run_hold_a: assert property (
    RUN_I && $past(RUN_I) && $past(RUN_I, 2)
    |-> $stable({CLK_SRC_EXT_O, BAND_CODE_O, DIV_ACTIVE_O}))
    else $error("setting changed in run");
  band_code_a: assert property (BAND_CODE_O inside {6'h02, 6'h04,
    6'h08, 6'h10, 6'h20}) else $error("band code illegal");
  div_factor_a: assert property (div_ok)
    else $error("divider not permitted");
  tick_idle_a: assert property (
    !RUN_I && !$past(RUN_I) |-> !SAMPLE_TICK_O)
    else $error("tick while stopped");
  tick_gap_a: assert property (
    SAMPLE_TICK_O && DIV_ACTIVE_O != 11'h001 |=> !SAMPLE_TICK_O)
    else $error("ticks too close");
  pll_tick_a: assert property (RUN_I && $past(RUN_I) && !CLK_SRC_EXT_O
    && DIV_ACTIVE_O == 11'h001 && PLL_TICK_I |=> SAMPLE_TICK_O)
    else $error("internal edge lost");
  ext_tick_a: assert property (RUN_I && $past(RUN_I) && CLK_SRC_EXT_O
    && DIV_ACTIVE_O == 11'h001 && $rose(EXT_CLK_I) |=> SAMPLE_TICK_O)
    else $error("connector edge lost");
endmodule // ecs_clock_select_mon

bind ecs_clock_select ecs_clock_select_mon #(.REG_DW(REG_DW)) mon_i (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .RUN_I(RUN_I),
  .EXT_CLK_I(EXT_CLK_I), .PLL_TICK_I(PLL_TICK_I),
  .CLK_SRC_EXT_O(CLK_SRC_EXT_O), .BAND_CODE_O(BAND_CODE_O),
  .DIV_ACTIVE_O(DIV_ACTIVE_O), .SAMPLE_TICK_O(SAMPLE_TICK_O));

// ===== sim/ecs_ext_src.sv
// Model of the clock source on the external clock connector
`timescale 1ns/1ps
// ------------
// Clock source
// ------------
module ecs_ext_src #(
  parameter int HALF = 2
) (
  input wire logic clk_i,
  input wire logic en_i,
  output logic ext_clk_o
);
  int cnt = 0;
  initial ext_clk_o = 1'b0;
  // 12.5 MHz: above 1 MHz, below 125 MS/s, inside burst small
  // Stands low outside frames, so a stale edge never reaches the block
  always @(posedge clk_i) begin
    if (!en_i) begin
      ext_clk_o <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      ext_clk_o <= ~ext_clk_o;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ecs_ext_src

// ===== sim/testbench.sv
// Testbench of the sample-clock source selection block
`timescale 1ns/1ps
// ---------
// Testbench
// ---------
module testbench;
  import ecs_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, fifo = 0, coe = 0, run = 0;
  logic pll = 0, src_en = 0, ext, rvalid, src, term, berr, tick;
  logic [15:0] addr = '0;
  logic [31:0] wdata = '0, rate = '0, rdata;
  logic [3:0] ch = 4'h1;
  logic [5:0] band;
  logic [ECS_DIV_W-1:0] div;
  int num_errors = 0, n_checks = 0, cyc = 0, n;
  always #10 clk = ~clk;
  ecs_clock_select ecs_clock_select_i (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CH_ENABLE_I(ch),
    .FIFO_MODE_I(fifo), .SAMPLE_RATE_I(rate), .CLK_OUT_EN_I(coe),
    .RUN_I(run), .EXT_CLK_I(ext), .PLL_TICK_I(pll), .CLK_SRC_EXT_O(src),
    .TERM_EN_O(term), .BAND_CODE_O(band), .BAND_ERR_O(berr),
    .DIV_ACTIVE_O(div), .SAMPLE_TICK_O(tick));
  ecs_ext_src #(.HALF(2)) ecs_ext_src_i (.clk_i(clk), .en_i(src_en),
    .ext_clk_o(ext));
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rreg(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1; chk(32'(rvalid), 32'h1); chk(rdata, exp);
  endtask
  task count_ticks(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(posedge clk); #1; n += int'(tick);
    end
  endtask
  task t_reset;
    chk({src, term, berr, tick, band}, 32'h02);
    chk(32'(div), 32'h1);
    rreg(ECS_REG_EXT_SEL, 32'h0); rreg(ECS_REG_TERM, 32'h0);
    rreg(ECS_REG_BAND, 32'h2); rreg(ECS_REG_DIVIDER, 32'h1);
  endtask
  task t_band;
    logic [5:0] codes [5];
    codes = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    for (int k = 0; k < 5; k++) begin
      wreg(ECS_REG_BAND, 32'(codes[k]));
      rreg(ECS_REG_BAND, 32'(codes[k]));
    end
    wreg(ECS_REG_BAND, 32'h3); rreg(ECS_REG_BAND, 32'h20);
    rreg(16'h4e00, 32'h0);
  endtask
  task t_div;
    wreg(ECS_REG_DIVIDER, 32'h7); rreg(ECS_REG_DIVIDER, 32'h8);
    wreg(ECS_REG_DIVIDER, 32'h9); rreg(ECS_REG_DIVIDER, 32'h8);
    wreg(ECS_REG_DIVIDER, 32'h0); rreg(ECS_REG_DIVIDER, 32'h1);
    wreg(ECS_REG_DIVIDER, 32'hbb8); rreg(ECS_REG_DIVIDER, 32'h7d0);
    @(posedge clk); rate <= 32'h3e8;
    wreg(ECS_REG_DIVIDER, 32'h5); rreg(ECS_REG_DIVIDER, 32'h3e8);
    @(posedge clk); rate <= 32'h0;
  endtask
  task t_term_band;
    wreg(ECS_REG_TERM, 32'h1);
    coe <= 1'b1;
    repeat (2) @(posedge clk); #1; chk(32'(term), 32'h0);
    @(posedge clk);
    coe <= 1'b0;
    repeat (2) @(posedge clk); #1; chk(32'(term), 32'h1);
    @(posedge clk);
    ch <= 4'hf;
    wreg(ECS_REG_BAND, 32'h8);
    repeat (2) @(posedge clk); #1; chk(32'(berr), 32'h1);
    @(posedge clk);
    fifo <= 1'b1;
    repeat (2) @(posedge clk); #1; chk(32'(berr), 32'h0);
    @(posedge clk);
    ch <= 4'h1;
    fifo <= 1'b0;
    wreg(ECS_REG_BAND, 32'h4);
    repeat (2) @(posedge clk); #1; chk(32'(berr), 32'h0);
  endtask
  task t_pll;
    wreg(ECS_REG_DIVIDER, 32'h2);
    @(posedge clk); run <= 1'b1; pll <= 1'b1;
    count_ticks(20); chk(32'(n), 32'd9);
    wreg(ECS_REG_DIVIDER, 32'h1); #1; chk(32'(div), 32'h2);
    @(posedge clk); run <= 1'b0;
    @(posedge clk); run <= 1'b1;
    count_ticks(3); chk({src, 5'h0, div}, 32'h1);
    @(posedge clk); run <= 1'b0; pll <= 1'b0;
  endtask
  task t_ext;
    wreg(ECS_REG_EXT_SEL, 32'h1);
    src_en <= 1'b1;
    repeat (6) @(posedge clk);
    run <= 1'b1;
    count_ticks(40);
    chk({src, 31'(n > 8 && n < 11)}, 32'h80000001);
    chk(32'(band), {26'h0, ECS_BAND_BURST_SMALL});
    @(posedge clk);
    run <= 1'b0;
    src_en <= 1'b0;
    wreg(ECS_REG_EXT_SEL, 32'h0);
  endtask
  // Ceiling well above the under two hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk); #1;
    t_reset(); t_band(); t_div(); t_term_band(); t_pll(); t_ext();
    conclude();
  end
endmodule // testbench
